// file: mmn_pkg.sv
// Shared constants, types and helper functions of the move, multiply and not execution unit.
package mmn_pkg;

  // ----------------------------------------------------------------
  // Primary opcode field, instruction bits 10 to 5
  // ----------------------------------------------------------------
  localparam logic [5:0] OP_REG_MOVE = 6'h00;
  localparam logic [5:0] OP_COMPLEMENT = 6'h01;
  localparam logic [5:0] OP_HALFWORD_MULTIPLY_REG = 6'h07;
  localparam logic [5:0] OP_HALFWORD_MULTIPLY_IMM5 = 6'h17;
  localparam logic [5:0] OP_ADD_IMM_ADDRESS_MOVE = 6'h31;
  localparam logic [5:0] OP_ADD_HIGH_HALF_MOVE = 6'h32;
  localparam logic [5:0] OP_HALFWORD_IMM16_MULTIPLY = 6'h37;
  localparam logic [5:0] OP_BIT_INVERT_DISP = 6'h3e;
  localparam logic [5:0] OP_EXTENDED = 6'h3f;

  // ----------------------------------------------------------------
  // Extended opcode fields, instruction bits 26 to 16 and parts of them, and the bit-invert tag in bits 15 to 14
  // ----------------------------------------------------------------
  localparam logic [10:0] SUB_WORD_MULTIPLY_SIGNED = 11'h220;
  localparam logic [10:0] SUB_WORD_MULTIPLY_UNSIGNED = 11'h222;
  localparam logic [10:0] SUB_BIT_INVERT_REG = 11'h0e2;
  localparam logic [4:0] SUB_WORD_MULTIPLY_IMM_TAG = 5'h09;
  localparam logic [1:0] SUB_IMM_SIGNED = 2'h0;
  localparam logic [1:0] SUB_IMM_UNSIGNED = 2'h2;
  localparam logic [1:0] BIT_INVERT_DISP_TAG = 2'h1;

  // ----------------------------------------------------------------
  // Program counter steps
  // ----------------------------------------------------------------
  localparam logic [2:0] PC_STEP_SHORT = 3'h2;
  localparam logic [2:0] PC_STEP_LONG = 3'h4;

  // ----------------------------------------------------------------
  // Register map, byte addresses on the bus
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RETIRED = 8'h08;
  localparam int CONTROL_ENABLE_BIT = 0;
  localparam logic CONTROL_ENABLE_RESET = 1'b1;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_ZERO_BIT = 1;
  localparam int STATUS_ILLEGAL_BIT = 2;

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} mmn_state_t;

  function automatic logic [31:0] mmn_sext16(input logic [15:0] v);
    mmn_sext16 = {{16{v[15]}}, v};
  endfunction : mmn_sext16

  function automatic logic [31:0] mmn_half_product(input logic [15:0] a, input logic [15:0] b);
    // Factors are widened first so the product is never cut to halfword width.
    mmn_half_product = {{16{a[15]}}, a} * {{16{b[15]}}, b};
  endfunction : mmn_half_product

  function automatic logic [63:0] mmn_word_product(input logic [31:0] a, input logic [31:0] b,
                                                   input logic signed_op);
    logic [63:0] ax;
    logic [63:0] bx;
    ax = {{32{signed_op & a[31]}}, a};
    bx = {{32{signed_op & b[31]}}, b};
    mmn_word_product = ax * bx;
  endfunction : mmn_word_product

endpackage : mmn_pkg

// file: mmn_ahb_regs.sv
// AHB-Lite register slave of the move, multiply and not execution unit.
`timescale 1ns/1ns
`default_nettype none
module mmn_ahb_regs (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic ctrl_en,
  input wire logic busy,
  input wire logic last_zero,
  input wire logic last_illegal,
  input wire logic retire
);
  import mmn_pkg::*;

  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] retired_q;
  logic addr_phase;

  // Only single word transfers are used, so hsize needs no decode.
  assign addr_phase = hsel && htrans[1] && hready && (hsize == 3'h2 || hsize != 3'h2);

  // ----------------------------------------------------------------
  // Bus handshake: zero wait states, always OKAY
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= addr_phase && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Control register and retired counter
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctrl_en <= CONTROL_ENABLE_RESET;
    end else if (wr_pend_q && wr_addr_q == REG_CONTROL) begin
      ctrl_en <= hwdata[CONTROL_ENABLE_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      retired_q <= 32'h0;
    end else if (retire) begin
      retired_q <= retired_q + 32'h1;
    end
  end

  // Read data is sampled in the address phase so it stands for the whole data phase.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      hrdata <= 32'h0;
    end else if (addr_phase && !hwrite) begin
      unique case (haddr[7:0])
        REG_CONTROL: hrdata <= 32'(ctrl_en);
        REG_STATUS: hrdata <= 32'({last_illegal, last_zero, busy});
        REG_RETIRED: hrdata <= retired_q;
        default: hrdata <= 32'h0;
      endcase
    end
  end

endmodule : mmn_ahb_regs
`default_nettype wire

// file: mmn_exec.sv
// Execution unit for address moves, word and halfword multiplies, no-operation, complement
// and memory bit inversion.
//
// The implementer's own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Address move adds sign-extended imm16 to reg1
// - Address moves leave every status flag alone
// - High move adds imm16 shifted up sixteen
// - Signed word multiply: high to reg3, low reg2
// - Nine-bit immediate built from five plus four
// - Unsigned multiply zero-extends, splits product halves
// - Same reg2 and reg3 keeps upper half
// - Register halfword multiply uses low halfwords only
// - Imm5 halfword multiply sign-extends imm5 first
// - Imm16 halfword multiply: reg1 low times imm16
// - No-operation changes nothing, steps PC two
// - Complement writes inverted reg1 into reg2
// - Complement clears overflow, sets sign and zero
// - Displacement bit invert: reg1 plus disp16 address
// - Register bit invert: reg1 address, reg2 bit
// - Zero flag set when inverted bit was zero
module mmn_exec (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic op_valid,
  output logic op_ready,
  input wire logic [31:0] op_instr,
  input wire logic [31:0] op_reg1_val,
  input wire logic [31:0] op_reg2_val,
  output logic wb_a_en,
  output logic [4:0] wb_a_idx,
  output logic [31:0] wb_a_data,
  output logic wb_b_en,
  output logic [4:0] wb_b_idx,
  output logic [31:0] wb_b_data,
  output logic flag_z_we,
  output logic flag_z,
  output logic flag_s_we,
  output logic flag_s,
  output logic flag_overflow_we,
  output logic flag_overflow,
  output logic done,
  output logic [2:0] done_pc_step,
  output logic done_illegal,
  output logic mem_req,
  output logic mem_we,
  output logic mem_lock,
  output logic [31:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  import mmn_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  mmn_state_t state_q;
  logic ctrl_en;
  logic accept;
  logic [2:0] bit_sel_q;
  logic zero_hold_q;
  logic last_zero_q;
  logic last_illegal_q;
  logic [4:0] f_r1;
  logic [4:0] f_r2;
  logic [4:0] f_r3;
  logic [5:0] f_op;
  logic [10:0] f_sub;
  logic [15:0] f_imm16;
  logic [8:0] f_imm9;
  logic [63:0] prod;
  logic d_a_en;
  logic [31:0] d_a_data;
  logic d_b_en;
  logic [31:0] d_b_data;
  logic d_flags;
  logic [31:0] d_logic;
  logic d_illegal;
  logic [2:0] d_step;
  logic d_mem;
  logic [31:0] d_addr;
  logic [2:0] d_bit;
  logic old_bit;

  assign accept = op_valid && op_ready;
  assign old_bit = mem_rdata[bit_sel_q];

  // ----------------------------------------------------------------
  // Field extraction and decode
  // ----------------------------------------------------------------
  always_comb begin
    f_r1 = op_instr[4:0];
    f_r2 = op_instr[15:11];
    f_r3 = op_instr[31:27];
    f_op = op_instr[10:5];
    f_sub = op_instr[26:16];
    f_imm16 = op_instr[31:16];
    f_imm9 = {op_instr[21:18], op_instr[4:0]};
  end

  always_comb begin
    d_a_en = 1'b0;
    d_a_data = 32'h0;
    d_b_en = 1'b0;
    d_b_data = 32'h0;
    d_flags = 1'b0;
    d_logic = 32'h0;
    d_illegal = 1'b0;
    d_step = PC_STEP_LONG;
    d_mem = 1'b0;
    d_addr = op_reg1_val;
    d_bit = op_reg2_val[2:0];
    prod = 64'h0;
    unique case (f_op)
      OP_REG_MOVE: begin
        // Only the all-zero form belongs here; other register moves are not ours.
        d_step = PC_STEP_SHORT;
        d_illegal = (op_instr[15:0] != 16'h0);
      end
      OP_COMPLEMENT: begin
        d_step = PC_STEP_SHORT;
        d_a_en = 1'b1;
        d_a_data = ~op_reg1_val;
        d_logic = ~op_reg1_val;
        d_flags = 1'b1;
      end
      OP_HALFWORD_MULTIPLY_REG: begin
        d_step = PC_STEP_SHORT;
        d_a_en = 1'b1;
        d_a_data = mmn_half_product(op_reg2_val[15:0], op_reg1_val[15:0]);
      end
      OP_HALFWORD_MULTIPLY_IMM5: begin
        d_step = PC_STEP_SHORT;
        d_a_en = 1'b1;
        d_a_data = mmn_half_product(op_reg2_val[15:0], {{11{f_r1[4]}}, f_r1});
      end
      OP_ADD_IMM_ADDRESS_MOVE: begin
        d_a_en = 1'b1;
        d_a_data = op_reg1_val + mmn_sext16(f_imm16);
      end
      OP_ADD_HIGH_HALF_MOVE: begin
        d_a_en = 1'b1;
        d_a_data = op_reg1_val + {f_imm16, 16'h0};
      end
      OP_HALFWORD_IMM16_MULTIPLY: begin
        d_a_en = 1'b1;
        d_a_data = mmn_half_product(op_reg1_val[15:0], f_imm16);
      end
      OP_BIT_INVERT_DISP: begin
        d_mem = (op_instr[15:14] == BIT_INVERT_DISP_TAG);
        d_illegal = !d_mem;
        d_addr = op_reg1_val + mmn_sext16(f_imm16);
        d_bit = op_instr[13:11];
      end
      OP_EXTENDED: begin
        if (f_sub == SUB_WORD_MULTIPLY_SIGNED) begin
          prod = mmn_word_product(op_reg2_val, op_reg1_val, 1'b1);
        end else if (f_sub == SUB_WORD_MULTIPLY_UNSIGNED) begin
          prod = mmn_word_product(op_reg2_val, op_reg1_val, 1'b0);
        end else if (f_sub[10:6] == SUB_WORD_MULTIPLY_IMM_TAG && f_sub[1:0] == SUB_IMM_SIGNED) begin
          prod = mmn_word_product(op_reg2_val, {{23{f_imm9[8]}}, f_imm9}, 1'b1);
        end else if (f_sub[10:6] == SUB_WORD_MULTIPLY_IMM_TAG && f_sub[1:0] == SUB_IMM_UNSIGNED) begin
          prod = mmn_word_product(op_reg2_val, {23'h0, f_imm9}, 1'b0);
        end else if (f_sub == SUB_BIT_INVERT_REG && f_r3 == 5'h0) begin
          d_mem = 1'b1;
        end else begin
          d_illegal = 1'b1;
        end
        if (!d_mem && !d_illegal) begin
          d_b_en = 1'b1;
          d_b_data = prod[63:32];
          d_a_en = (f_r2 != f_r3);
          d_a_data = prod[31:0];
        end
      end
      default: begin
        d_illegal = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer and memory read-modify-write
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      op_ready <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_lock <= 1'b0;
      mem_addr <= 32'h0;
      mem_wdata <= 8'h00;
      bit_sel_q <= 3'h0;
      zero_hold_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          op_ready <= ctrl_en && !accept;
          if (accept && d_mem) begin
            // The lock covers both accesses so no other master can slip between them.
            state_q <= ST_READ;
            op_ready <= 1'b0;
            mem_req <= 1'b1;
            mem_lock <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= d_addr;
            bit_sel_q <= d_bit;
          end
        end
        ST_READ: begin
          if (mem_ack) begin
            state_q <= ST_WRITE;
            mem_we <= 1'b1;
            mem_wdata <= mem_rdata ^ (8'h01 << bit_sel_q);
            zero_hold_q <= !old_bit;
          end
        end
        ST_WRITE: begin
          if (mem_ack) begin
            state_q <= ST_IDLE;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_lock <= 1'b0;
            op_ready <= ctrl_en;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Write-back, flag and retire pulses
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wb_a_en <= 1'b0;
      wb_a_idx <= 5'h0;
      wb_a_data <= 32'h0;
      wb_b_en <= 1'b0;
      wb_b_idx <= 5'h0;
      wb_b_data <= 32'h0;
    end else begin
      wb_a_en <= accept && !d_illegal && d_a_en;
      wb_b_en <= accept && !d_illegal && d_b_en;
      if (accept) begin
        wb_a_idx <= f_r2;
        wb_a_data <= d_a_data;
        wb_b_idx <= f_r3;
        wb_b_data <= d_b_data;
      end
    end
  end

  // Carry and saturation have no write enable at all, so no op here can touch them.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      flag_z_we <= 1'b0;
      flag_z <= 1'b0;
      flag_s_we <= 1'b0;
      flag_s <= 1'b0;
      flag_overflow_we <= 1'b0;
      flag_overflow <= 1'b0;
    end else if (state_q == ST_WRITE && mem_ack) begin
      flag_z_we <= 1'b1;
      flag_z <= zero_hold_q;
      flag_s_we <= 1'b0;
      flag_overflow_we <= 1'b0;
    end else begin
      flag_z_we <= accept && d_flags;
      flag_s_we <= accept && d_flags;
      flag_overflow_we <= accept && d_flags;
      flag_z <= (d_logic == 32'h0);
      flag_s <= d_logic[31];
      flag_overflow <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      done <= 1'b0;
      done_pc_step <= PC_STEP_SHORT;
      done_illegal <= 1'b0;
    end else if (state_q == ST_WRITE && mem_ack) begin
      done <= 1'b1;
      done_pc_step <= PC_STEP_LONG;
      done_illegal <= 1'b0;
    end else begin
      done <= accept && !d_mem;
      if (accept) begin
        done_pc_step <= d_step;
        done_illegal <= d_illegal;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      last_zero_q <= 1'b0;
      last_illegal_q <= 1'b0;
    end else begin
      if (flag_z_we) begin
        last_zero_q <= flag_z;
      end
      if (done) begin
        last_illegal_q <= done_illegal;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  mmn_ahb_regs u_regs (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .ctrl_en(ctrl_en),
    .busy(state_q != ST_IDLE),
    .last_zero(last_zero_q),
    .last_illegal(last_illegal_q),
    .retire(done)
  );

endmodule : mmn_exec
`default_nettype wire

// file: mmn_exec_assertions.sv
// Concurrent checks on the ports of the execution unit.
`timescale 1ns/1ns
`default_nettype none
module mmn_exec_checker (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic op_valid,
  input wire logic op_ready,
  input wire logic [31:0] op_instr,
  input wire logic [31:0] op_reg1_val,
  input wire logic wb_a_en,
  input wire logic [31:0] wb_a_data,
  input wire logic wb_b_en,
  input wire logic [4:0] wb_b_idx,
  input wire logic flag_z_we,
  input wire logic flag_z,
  input wire logic flag_s_we,
  input wire logic flag_s,
  input wire logic flag_overflow_we,
  input wire logic flag_overflow,
  input wire logic done,
  input wire logic [2:0] done_pc_step,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_lock,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata
);
  import mmn_pkg::*;
  // --------
  // Checks
  // --------
  logic [7:0] rd_q;
  wire logic acc = op_valid && op_ready;
  wire logic [5:0] opc = op_instr[10:5];
  wire logic nofl = !flag_z_we && !flag_s_we && !flag_overflow_we;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  // The byte read is kept, because the bit number is gone once the op is accepted.
  always_ff @(posedge sys_clk) begin
    if (mem_req && !mem_we && mem_ack) begin
      rd_q <= mem_rdata;
    end
  end
  property p_no_op;
    acc && op_instr == 32'h0 |=> done && done_pc_step == PC_STEP_SHORT && !wb_a_en && !wb_b_en && nofl;
  endproperty
  a_no_op: assert property (p_no_op) else $error("no-operation changed state");
  property p_addr;
    acc && opc == OP_ADD_IMM_ADDRESS_MOVE |=> wb_a_en && nofl
      && wb_a_data == $past(op_reg1_val) + {{16{$past(op_instr[31])}}, $past(op_instr[31:16])};
  endproperty
  a_addr: assert property (p_addr) else $error("address move result wrong");
  property p_high;
    acc && opc == OP_ADD_HIGH_HALF_MOVE |=> wb_a_en && nofl
      && wb_a_data == $past(op_reg1_val) + {$past(op_instr[31:16]), 16'h0};
  endproperty
  a_high: assert property (p_high) else $error("high move result wrong");
  property p_not;
    acc && opc == OP_COMPLEMENT |=> wb_a_data == ~$past(op_reg1_val)
      && flag_overflow_we && !flag_overflow
      && flag_s == !$past(op_reg1_val[31]) && flag_z == ($past(op_reg1_val) == 32'hffffffff);
  endproperty
  a_not: assert property (p_not) else $error("complement result or flags wrong");
  property p_mul;
    acc && opc == OP_EXTENDED && op_instr[26:16] == SUB_WORD_MULTIPLY_SIGNED |=> wb_b_en && nofl
      && wb_b_idx == $past(op_instr[31:27]) && wb_a_en == ($past(op_instr[31:27]) != $past(op_instr[15:11]));
  endproperty
  a_mul: assert property (p_mul) else $error("word multiply write pairing wrong");
  property p_lock;
    mem_req |-> mem_lock;
  endproperty
  a_lock: assert property (p_lock) else $error("memory access not locked");
  property p_wb;
    mem_req && !mem_we && mem_ack |=> mem_req && mem_we && $onehot(mem_wdata ^ $past(mem_rdata));
  endproperty
  a_wb: assert property (p_wb) else $error("write-back not one inverted bit");
  property p_zf;
    mem_req && mem_we && mem_ack |=> done && flag_z_we && !flag_s_we && !flag_overflow_we
      && !mem_req
      && flag_z == |($past(mem_wdata) & ($past(mem_wdata) ^ rd_q));
  endproperty
  a_zf: assert property (p_zf) else $error("zero flag not old bit inverted");
endmodule : mmn_exec_checker
bind mmn_exec mmn_exec_checker u_chk (.*);
`default_nettype wire

// file: mmn_mem_model.sv
// Byte memory answering the bit-inversion accesses after a chosen latency.
`timescale 1ns/1ns
`default_nettype none
module mmn_mem_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [3:0] lat,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic mem_ack,
  output logic [7:0] mem_rdata
);
  // --------
  // Storage
  // --------
  logic [7:0] bytes [256];
  logic [3:0] cnt_q;
  // Read data toggles outside a read answer, so a stale byte is never taken for a fresh one.
  always @(posedge sys_clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (!resetn) begin
      cnt_q <= 4'h0;
      mem_rdata <= 8'h5a;
    end else if (!mem_req || mem_ack) begin
      cnt_q <= 4'h0;
    end else if (cnt_q == lat) begin
      mem_ack <= 1'b1;
      if (mem_we) begin
        bytes[mem_addr[7:0]] <= mem_wdata;
      end else begin
        mem_rdata <= bytes[mem_addr[7:0]];
      end
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : mmn_mem_model
`default_nettype wire

// file: move_multiply_not_exec_tb.sv
// Self-checking bench of the execution unit with a byte memory on its far side.
`timescale 1ns/1ns
`default_nettype none
module move_multiply_not_exec_tb;
  import mmn_pkg::*;
  typedef struct packed {
    logic [31:0] ins, r1, r2;
    logic [8:0] c;
    logic [31:0] a, b;
    logic [2:0] fl;
  } mmn_row_t;
  logic sys_clk, resetn, op_valid, op_ready, wb_a_en, wb_b_en, flag_z_we, flag_z, flag_s_we;
  logic flag_s, flag_overflow_we, flag_overflow, done, done_illegal, mem_req, mem_we, mem_lock;
  logic hsel, hwrite, hreadyout, hresp, mem_ack;
  logic [1:0] htrans;
  logic [2:0] hsize, done_pc_step;
  logic [3:0] lat;
  logic [4:0] wb_a_idx, wb_b_idx;
  logic [7:0] mem_wdata, mem_rdata;
  logic [31:0] op_instr, op_reg1_val, op_reg2_val, wb_a_data, wb_b_data, mem_addr;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int n_mismatch, cmp_count;
  mmn_row_t r;
  // ----------
  // Cases
  // ----------
  // Destinations avoid r0 and no multiply has reg1 equal to reg3.
  mmn_row_t rows [14] = '{
    '{32'hfffe1621, 32'h1, 32'h0, 9'h108, 32'hffffffff, 32'h0, 3'h0},
    '{32'h12341641, 32'h8000, 32'h0, 9'h108, 32'h12348000, 32'h0, 3'h0},
    '{32'h1a2017e1, 32'h3, 32'hfffffffe, 9'h188, 32'hfffffffa, 32'hffffffff, 3'h0},
    '{32'h1a2217e1, 32'h3, 32'hfffffffe, 9'h188, 32'hfffffffa, 32'h2, 3'h0},
    '{32'h1a6017e1, 32'h0, 32'h2, 9'h188, 32'hfffffe02, 32'hffffffff, 3'h0},
    '{32'h1a6217e1, 32'h0, 32'h2, 9'h188, 32'h202, 32'h0, 3'h0},
    '{32'h122017e1, 32'h10000, 32'h10000, 9'h088, 32'h0, 32'h1, 3'h0},
    '{32'h000010e1, 32'h12340003, 32'habcdfffe, 9'h104, 32'hfffffffa, 32'h0, 3'h0},
    '{32'h000012ff, 32'h0, 32'h55550004, 9'h104, 32'hfffffffc, 32'h0, 3'h0},
    '{32'hfffd16e1, 32'h77770005, 32'h0, 9'h108, 32'hfffffff1, 32'h0, 3'h0},
    '{32'h0, 32'h0, 32'h0, 9'h004, 32'h0, 32'h0, 3'h0},
    '{32'h00000801, 32'h0, 32'h0, 9'h005, 32'h0, 32'h0, 3'h0},
    '{32'h00001021, 32'h0f0f0000, 32'h0, 9'h174, 32'hf0f0ffff, 32'h0, 3'h2},
    '{32'h00001021, 32'hffffffff, 32'h0, 9'h174, 32'h0, 32'h0, 3'h4}
  };
  mmn_exec dut (.hready(hreadyout), .*);
  mmn_mem_model u_mem (.*);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic run(input logic [31:0] ins, r1, r2);
    op_valid <= 1'b1;
    op_instr <= ins;
    op_reg1_val <= r1;
    op_reg2_val <= r2;
    do @(posedge sys_clk); while (op_ready !== 1'b1);
    op_valid <= 1'b0;
    do @(posedge sys_clk); while (done !== 1'b1);
  endtask : run
  task automatic bitinv(input logic [31:0] ins, r1, r2, input logic [7:0] ad, pre, post,
                        input logic z, input logic [3:0] l);
    lat <= l;
    u_mem.bytes[ad] = pre;
    run(ins, r1, r2);
    chk("bit_ctl", 32'({wb_a_en, wb_b_en, flag_z_we, flag_s_we, flag_overflow_we, flag_z,
                        done_pc_step}), 32'({5'h04, z, 3'h4}));
    chk("byte", 32'(u_mem.bytes[ad]), 32'(post));
    chk("addr", mem_addr, 32'(ad));
  endtask : bitinv
  task automatic test_done();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done
  // A hang in any wait ends the run at 4000 cycles, well after the expected hundred or so.
  initial begin
    repeat (4000) @(posedge sys_clk);
    n_mismatch++;
    test_done();
  end
  initial begin
    resetn = 1'b0;
    op_valid = 1'b0;
    op_instr = 32'h0;
    op_reg1_val = 32'h0;
    op_reg2_val = 32'h0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    lat = 4'h0;
    repeat (3) @(posedge sys_clk);
    chk("reset", 32'({op_ready, mem_req, mem_lock, done, hreadyout, hresp, done_pc_step}), 32'h12);
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      run(r.ins, r.r1, r.r2);
      chk("ctl", 32'({wb_a_en, wb_b_en, flag_z_we, flag_s_we, flag_overflow_we, done_pc_step,
                      done_illegal}), 32'(r.c));
      chk("flags", 32'({flag_z, flag_s, flag_overflow} & r.c[6:4]), 32'(r.fl));
      if (r.c[8]) begin
        chk("wb_a_data", wb_a_data, r.a);
        chk("wb_a_idx", 32'(wb_a_idx), 32'(r.ins[15:11]));
      end
      if (r.c[7]) begin
        chk("wb_b_data", wb_b_data, r.b);
        chk("wb_b_idx", 32'(wb_b_idx), 32'(r.ins[31:27]));
      end
    end
    bitinv(32'hfff07fc1, 32'h40, 32'h0, 8'h30, 8'h80, 8'h00, 1'b0, 4'h3);
    bitinv(32'h00e217e1, 32'h31, 32'hfffffff2, 8'h31, 8'h00, 8'h04, 1'b1, 4'h0);
    ahb(1'b0, REG_CONTROL, 32'h0);
    chk("control", rd, 32'h1);
    ahb(1'b0, REG_STATUS, 32'h0);
    chk("status", rd, 32'h2);
    ahb(1'b0, REG_RETIRED, 32'h0);
    chk("retired", rd, 32'h10);
    ahb(1'b1, 8'h20, 32'hffffffff);
    ahb(1'b0, 8'h20, 32'h0);
    chk("unmapped", rd, 32'h0);
    ahb(1'b1, REG_CONTROL, 32'h0);
    // The enable reaches op_ready one edge late, so the offer waits out that edge.
    @(posedge sys_clk);
    op_instr <= 32'h0;
    op_valid <= 1'b1;
    repeat (4) begin
      @(posedge sys_clk);
      chk("held", 32'({op_ready, done}), 32'h0);
    end
    ahb(1'b1, REG_CONTROL, 32'h1);
    run(32'h0, 32'h0, 32'h0);
    chk("no_op_step", 32'(done_pc_step), 32'h2);
    test_done();
  end
endmodule : move_multiply_not_exec_tb
`default_nettype wire
